// *** rtl/cps_map.svh ***
`ifndef CPS_MAP_SVH
`define CPS_MAP_SVH
// Configuration mode codes
`define CPS_MODE_W         3
`define CPS_MODE_NONE      3'h0
`define CPS_MODE_SSPI      3'h1
`define CPS_MODE_I2C       3'h2
`define CPS_MODE_MSPI      3'h3
`define CPS_MODE_QSPI      3'h4
`define CPS_MODE_CHAIN     3'h5
// Least low time on the start pin, ns, and its cycle count at 25 MHz
`define CPS_START_LOW_NS   80
`define CPS_CLK_NS         40
`define CPS_START_LOW_CYC  ((`CPS_START_LOW_NS + `CPS_CLK_NS - 1) / `CPS_CLK_NS)
// Initialization time, ns, and its cycle count
`define CPS_INIT_NS        400
`define CPS_INIT_CYC       (`CPS_INIT_NS / `CPS_CLK_NS)
`define CPS_CNT_W          4
`endif

// *** rtl/cps_pkg.sv ***
package cps_pkg;
    typedef enum logic [4:0] {
        CPS_IDLE     = 5'h01,
        CPS_INIT     = 5'h02,
        CPS_HOLDOFF  = 5'h04,
        CPS_LOAD     = 5'h08,
        CPS_WAKE     = 5'h10
    } cps_state_t;
endpackage : cps_pkg

// *** rtl/cps_pin_share.sv ***
`timescale 1ns/1ps
// Function
// RQ1 - Low start pin begins configuration
// RQ2 - Pull init status low when starting
// RQ3 - Release init status after initialization
// RQ4 - External low init status delays download
// RQ5 - Hold completion pin low during configuration
// RQ6 - Release completion pin when finished
// RQ7 - External low completion delays wake-up
// RQ8 - Scan select high gives scan pins
// RQ9 - Scan select low gives user role
// RQ10 - Other pins follow bitstream in user
// RQ11 - Unused configuration pins tri-stated
// RQ12 - Detect slave SPI or I2C by activity
// RQ13 - Configuration pins freed after completion
// RQ14 - Slave SPI: host drives, device returns
// RQ15 - Master SPI: device drives clock, select
// RQ16 - Quad SPI uses four data lines
// RQ17 - I2C pins carry SDA and SCL
// RQ18 - Daisy chain drives select out
// RQ19 - Clock pins feed primary clock
// RQ20 - Handshake pins are open drain
`include "cps_map.svh"
module cps_pin_share (
    input  wire logic        clock_in,
    input  wire logic        reset_in,
    input  wire logic        link_clk_in,
    input  wire logic        config_start_n_in,
    input  wire logic        init_status_n_in,
    output logic             init_status_oe_out,
    input  wire logic        done_in,
    output logic             done_oe_out,
    input  wire logic        scan_sel_in,
    input  wire logic [2:0]  master_mode_in,
    input  wire logic        engine_done_in,
    input  wire logic        slave_chip_select_n_in,
    input  wire logic        slave_serial_in,
    output logic             slave_serial_out,
    output logic             slave_serial_oe_out,
    input  wire logic        eng_sso_in,
    output logic             eng_ssi_out,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_oe_out,
    input  wire logic        eng_sda_low_in,
    output logic             eng_sda_out,
    input  wire logic        eng_mclk_in,
    input  wire logic        eng_mcs_n_in,
    input  wire logic [3:0]  eng_mdata_in,
    input  wire logic [3:0]  eng_mdata_oe_in,
    output logic [3:0]       eng_mdata_out,
    output logic             master_clk_out,
    output logic             master_chip_select_n_out,
    output logic             master_ctl_oe_out,
    input  wire logic [3:0]  quad_io_in,
    output logic [3:0]       quad_io_out,
    output logic [3:0]       quad_io_oe_out,
    input  wire logic        eng_chain_cs_n_in,
    output logic             chain_select_out_n,
    output logic             chain_select_oe_out,
    input  wire logic [3:0]  user_scan_o_in,
    input  wire logic [3:0]  user_scan_oe_in,
    input  wire logic        tdo_in,
    output logic [3:0]       scan_pin_out,
    output logic [3:0]       scan_pin_oe_out,
    output logic [2:0]       scan_to_tap_out,
    input  wire logic [15:0] user_o_in,
    input  wire logic [15:0] user_oe_in,
    output logic [15:0]      cfg_pin_out,
    output logic [15:0]      cfg_pin_oe_out,
    output logic             user_mode_out,
    output logic [2:0]       mode_out,
    input  wire logic [1:0]  pclk_pin_in,
    output logic [1:0]       primary_clk_out
);
    cps_pkg::cps_state_t state_ff, nxt_state;
    logic [`CPS_MODE_W-1:0] mode_ff;
    logic [`CPS_CNT_W-1:0]  cnt_ff;
    logic [1:0] start_sync_ff, init_sync_ff, done_sync_ff, scan_sync_ff;
    logic [1:0] eng_done_sync_ff;
    logic       start_low;
    logic       ext_init_low;
    logic       ext_done_low;
    logic       cfg_active;
    logic       cs_l1_ff, cs_l2_ff, sda_l1_ff, sda_l2_ff, scl_l1_ff;
    logic       scl_l2_ff, scl_prev_ff, sspi_seen_ff, i2c_seen_ff;
    logic [1:0] sspi_sync_ff, i2c_sync_ff;

    // Pin inputs pass two flip-flops
    always_ff @(posedge clock_in) begin
        start_sync_ff    <= {start_sync_ff[0], config_start_n_in};
        init_sync_ff     <= {init_sync_ff[0], init_status_n_in};
        done_sync_ff     <= {done_sync_ff[0], done_in};
        scan_sync_ff     <= {scan_sync_ff[0], scan_sel_in};
        eng_done_sync_ff <= {eng_done_sync_ff[0], engine_done_in};
    end
    assign start_low    = ~start_sync_ff[1];
    assign ext_init_low = ~init_sync_ff[1];
    assign ext_done_low = ~done_sync_ff[1];

    // Slave activity seen on the link clock
    always_ff @(posedge link_clk_in) begin
        cs_l1_ff    <= slave_chip_select_n_in;
        cs_l2_ff    <= cs_l1_ff;
        sda_l1_ff   <= sda_in;
        sda_l2_ff   <= sda_l1_ff;
        scl_l1_ff   <= scl_in;
        scl_l2_ff   <= scl_l1_ff;
        scl_prev_ff <= scl_l2_ff;
        // I2C start: data low while clock high on two samples
        sspi_seen_ff <= ~cs_l2_ff; // [RQ12]
        i2c_seen_ff  <= scl_l2_ff & scl_prev_ff & ~sda_l2_ff; // [RQ12]
    end

    // Activity levels cross into the main clock
    always_ff @(posedge clock_in) begin
        sspi_sync_ff <= {sspi_sync_ff[0], sspi_seen_ff};
        i2c_sync_ff  <= {i2c_sync_ff[0], i2c_seen_ff};
    end

    // Configuration sequence
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            cps_pkg::CPS_IDLE:
                if (start_low && cnt_ff >= `CPS_CNT_W'(`CPS_START_LOW_CYC))
                    nxt_state = cps_pkg::CPS_INIT; // [RQ1]
            cps_pkg::CPS_INIT:
                if (cnt_ff >= `CPS_CNT_W'(`CPS_INIT_CYC))
                    nxt_state = cps_pkg::CPS_HOLDOFF; // [RQ3]
            cps_pkg::CPS_HOLDOFF:
                if (!ext_init_low)
                    nxt_state = cps_pkg::CPS_LOAD; // [RQ4]
            cps_pkg::CPS_LOAD:
                if (eng_done_sync_ff[1])
                    nxt_state = cps_pkg::CPS_WAKE;
            cps_pkg::CPS_WAKE:
                if (start_low)
                    nxt_state = cps_pkg::CPS_IDLE;
            default:
                nxt_state = cps_pkg::CPS_IDLE;
        endcase
    end

    // State register; reset starts a configuration
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            state_ff <= cps_pkg::CPS_INIT;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Cycle counter for start filter and initialization
    always_ff @(posedge clock_in) begin
        if (reset_in || nxt_state != state_ff) begin
            cnt_ff <= '0;
        end else if (state_ff == cps_pkg::CPS_IDLE && !start_low) begin
            cnt_ff <= '0;
        end else if (cnt_ff != '1) begin
            cnt_ff <= cnt_ff + `CPS_CNT_W'(1);
        end
    end

    // Mode detection during load
    always_ff @(posedge clock_in) begin
        if (reset_in || state_ff == cps_pkg::CPS_INIT) begin
            mode_ff <= `CPS_MODE_NONE;
        end else if (state_ff == cps_pkg::CPS_LOAD &&
                     mode_ff == `CPS_MODE_NONE) begin
            if (master_mode_in != `CPS_MODE_NONE)
                mode_ff <= master_mode_in;
            else if (sspi_sync_ff[1])
                mode_ff <= `CPS_MODE_SSPI; // [RQ12]
            else if (i2c_sync_ff[1])
                mode_ff <= `CPS_MODE_I2C; // [RQ12]
        end
    end

    // Open-drain handshakes: only pull low or release
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            init_status_oe_out <= 1'b1;
            done_oe_out        <= 1'b1;
        end else begin
            init_status_oe_out <= (nxt_state == cps_pkg::CPS_INIT); // [RQ2] [RQ20]
            done_oe_out <= (nxt_state != cps_pkg::CPS_WAKE) &&
                           (nxt_state != cps_pkg::CPS_IDLE); // [RQ5] [RQ6]
        end
    end

    // User mode waits for the completion line to go high
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            user_mode_out <= 1'b0;
        end else begin
            user_mode_out <= (nxt_state == cps_pkg::CPS_WAKE ||
                              nxt_state == cps_pkg::CPS_IDLE) &&
                             !ext_done_low; // [RQ7] [RQ13]
        end
    end

    assign cfg_active = ~user_mode_out;
    assign mode_out   = mode_ff;

    // Engine-side returns of sampled pins
    always_ff @(posedge clock_in) begin
        eng_ssi_out   <= slave_serial_in; // [RQ14]
        eng_sda_out   <= sda_in; // [RQ17]
        eng_mdata_out <= quad_io_in; // [RQ15]
    end

    // Pin muxing per mode
    always_comb begin
        slave_serial_out         = eng_sso_in;
        slave_serial_oe_out      = 1'b0;
        sda_oe_out               = 1'b0;
        master_clk_out           = eng_mclk_in;
        master_chip_select_n_out = eng_mcs_n_in;
        master_ctl_oe_out        = 1'b0;
        quad_io_out              = eng_mdata_in;
        quad_io_oe_out           = 4'h0; // [RQ11]
        chain_select_out_n       = eng_chain_cs_n_in;
        chain_select_oe_out      = 1'b0;
        if (cfg_active) begin
            case (mode_ff)
                `CPS_MODE_SSPI:
                    slave_serial_oe_out = ~slave_chip_select_n_in; // [RQ14]
                `CPS_MODE_I2C:
                    sda_oe_out = eng_sda_low_in; // [RQ17]
                `CPS_MODE_MSPI: begin
                    master_ctl_oe_out = 1'b1; // [RQ15]
                    quad_io_oe_out    = {3'h0, eng_mdata_oe_in[0]};
                end
                `CPS_MODE_QSPI: begin
                    master_ctl_oe_out = 1'b1;
                    quad_io_oe_out    = eng_mdata_oe_in; // [RQ16]
                end
                `CPS_MODE_CHAIN:
                    chain_select_oe_out = 1'b1; // [RQ18]
                default:
                    quad_io_oe_out = 4'h0;
            endcase
        end
    end

    // Scan pins: 0 tdi, 1 tdo, 2 tms, 3 tck
    always_comb begin
        if (scan_sync_ff[1]) begin
            scan_pin_out    = {3'h0, tdo_in} << 1; // [RQ8]
            scan_pin_oe_out = 4'h2;
        end else if (user_mode_out) begin
            scan_pin_out    = user_scan_o_in; // [RQ9]
            scan_pin_oe_out = user_scan_oe_in;
        end else begin
            scan_pin_out    = 4'h0;
            scan_pin_oe_out = 4'h0;
        end
    end
    assign scan_to_tap_out = {slave_serial_in, slave_chip_select_n_in, scl_in};

    // Other shared pins take the bitstream role in user mode
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_user
            assign cfg_pin_out[gi]    = user_o_in[gi]; // [RQ10]
            assign cfg_pin_oe_out[gi] = user_mode_out & user_oe_in[gi]; // [RQ13]
        end
    endgenerate

    // Clock pins pass to the primary clock tree in user mode
    assign primary_clk_out = user_mode_out ? pclk_pin_in : 2'h0; // [RQ19]

    property p_init_release;
        @(posedge clock_in) disable iff (reset_in)
        (state_ff == cps_pkg::CPS_HOLDOFF && ext_init_low) |=>
            state_ff != cps_pkg::CPS_LOAD;
    endproperty
    a_init_release: assert property (p_init_release) // [RQ4]
        else $error("download started while init held low");

    property p_done_low;
        @(posedge clock_in) disable iff (reset_in)
        (state_ff == cps_pkg::CPS_LOAD) |-> done_oe_out;
    endproperty
    a_done_low: assert property (p_done_low) // [RQ5]
        else $error("completion released during load");

    property p_wake_hold;
        @(posedge clock_in) disable iff (reset_in)
        ext_done_low |=> !user_mode_out;
    endproperty
    a_wake_hold: assert property (p_wake_hold) // [RQ7]
        else $error("woke while completion held low");

    property p_scan;
        @(posedge clock_in) disable iff (reset_in)
        scan_sync_ff[1] |-> scan_pin_oe_out == 4'h2;
    endproperty
    a_scan: assert property (p_scan) // [RQ8]
        else $error("scan pins not owned by scan port");

    property p_unused_tri;
        @(posedge clock_in) disable iff (reset_in)
        (cfg_active && mode_ff == `CPS_MODE_NONE) |->
            (quad_io_oe_out == 4'h0 && !chain_select_oe_out);
    endproperty
    a_unused_tri: assert property (p_unused_tri) // [RQ11]
        else $error("unused pin driven in configuration");

    property p_init_pull;
        @(posedge clock_in) disable iff (reset_in)
        (state_ff == cps_pkg::CPS_IDLE && nxt_state == cps_pkg::CPS_INIT)
            |=> init_status_oe_out;
    endproperty
    a_init_pull: assert property (p_init_pull) // [RQ2]
        else $error("init status not pulled at start");

    property p_user_free;
        @(posedge clock_in) disable iff (reset_in)
        !user_mode_out |-> cfg_pin_oe_out == 16'h0;
    endproperty
    a_user_free: assert property (p_user_free) // [RQ13]
        else $error("user pin driven before user mode");

    property p_done_rel;
        @(posedge clock_in) disable iff (reset_in)
        user_mode_out |-> !done_oe_out;
    endproperty
    a_done_rel: assert property (p_done_rel) // [RQ6]
        else $error("completion held in user mode");

    property p_init_free;
        @(posedge clock_in) disable iff (reset_in)
        (state_ff == cps_pkg::CPS_HOLDOFF) |-> !init_status_oe_out;
    endproperty
    a_init_free: assert property (p_init_free) // [RQ3]
        else $error("init status pulled after initialization");

    property p_user_exit;
        @(posedge clock_in) disable iff (reset_in)
        (state_ff != cps_pkg::CPS_WAKE && state_ff != cps_pkg::CPS_IDLE)
            |-> !user_mode_out;
    endproperty
    a_user_exit: assert property (p_user_exit) // [RQ1] [RQ13]
        else $error("user mode kept during configuration");

    property p_scan_user;
        @(posedge clock_in) disable iff (reset_in)
        (!scan_sync_ff[1] && user_mode_out) |->
            (scan_pin_oe_out == user_scan_oe_in);
    endproperty
    a_scan_user: assert property (p_scan_user) // [RQ9]
        else $error("scan pins not given to user logic");

    property p_pclk_off;
        @(posedge clock_in) disable iff (reset_in)
        !user_mode_out |-> (primary_clk_out == 2'h0);
    endproperty
    a_pclk_off: assert property (p_pclk_off) // [RQ19]
        else $error("clock pin passed before user mode");

    property p_mode_kept;
        @(posedge clock_in) disable iff (reset_in)
        (state_ff != cps_pkg::CPS_INIT && mode_ff != `CPS_MODE_NONE)
            |=> $stable(mode_ff);
    endproperty
    a_mode_kept: assert property (p_mode_kept) // [RQ12]
        else $error("detected mode changed outside restart");

    property p_slave_only;
        @(posedge clock_in) disable iff (reset_in)
        (mode_ff != `CPS_MODE_SSPI) |-> !slave_serial_oe_out;
    endproperty
    a_slave_only: assert property (p_slave_only) // [RQ12]
        else $error("slave output driven in another mode");

    property p_chain_sel;
        @(posedge clock_in) disable iff (reset_in)
        (cfg_active && mode_ff == `CPS_MODE_CHAIN) |-> chain_select_oe_out;
    endproperty
    a_chain_sel: assert property (p_chain_sel) // [RQ18]
        else $error("chain select not driven in chain mode");
endmodule : cps_pin_share

// *** verification/cps_host_model.sv ***
`timescale 1ns/1ps
// Configuration host: open-drain handshakes and slave bus activity
module cps_host_model (
    input  wire logic link_clk_in,
    input  wire logic init_oe_in,
    input  wire logic done_oe_in,
    input  wire logic sda_oe_in,
    output logic      start_n_out,
    output logic      init_n_out,
    output logic      done_out,
    output logic      cs_n_out,
    output logic      scl_out,
    output logic      sda_out
);
    logic hold_init = 1'b0;
    logic hold_done = 1'b0;
    logic start_low = 1'b0;
    logic sda_low   = 1'b0;
    logic scl_low   = 1'b0;
    logic cs_low    = 1'b0;
    // Pulled-up lines stay low while any party pulls them
    assign init_n_out  = ~(init_oe_in | hold_init);
    assign done_out    = ~(done_oe_in | hold_done);
    assign start_n_out = ~start_low;
    assign cs_n_out    = ~cs_low;
    assign scl_out     = ~scl_low;
    assign sda_out     = ~(sda_oe_in | sda_low);
    // Start condition: data falls while clock high, then clock falls
    task i2c_start;
        @(posedge link_clk_in) sda_low <= 1'b1;
        @(posedge link_clk_in) scl_low <= 1'b1;
        @(posedge link_clk_in) sda_low <= 1'b0;
    endtask : i2c_start
endmodule : cps_host_model

// *** verification/cps_pin_share_test.sv ***
`timescale 1ns/1ps
`include "cps_map.svh"
module cps_pin_share_test;
    logic        clock_in = 1'b0, link_clk_in = 1'b0, reset_in = 1'b1;
    logic        config_start_n_in, init_status_n_in, done_in, scl_in;
    logic        sda_in, slave_chip_select_n_in, scan_sel_in;
    logic        engine_done_in, slave_serial_in, eng_sso_in, tdo_in;
    logic        eng_sda_low_in, eng_mclk_in, eng_mcs_n_in;
    logic        eng_chain_cs_n_in, init_status_oe_out, done_oe_out;
    logic        slave_serial_out, slave_serial_oe_out, sda_oe_out;
    logic        eng_ssi_out, eng_sda_out, master_clk_out;
    logic        master_chip_select_n_out, master_ctl_oe_out;
    logic        chain_select_out_n, chain_select_oe_out, user_mode_out;
    logic [1:0]  pclk_pin_in, primary_clk_out;
    logic [2:0]  master_mode_in, scan_to_tap_out, mode_out;
    logic [3:0]  eng_mdata_in, eng_mdata_oe_in, eng_mdata_out, quad_io_in;
    logic [3:0]  quad_io_out, quad_io_oe_out, scan_pin_out, scan_pin_oe_out;
    logic [3:0]  user_scan_o_in, user_scan_oe_in;
    logic [15:0] user_o_in, user_oe_in, cfg_pin_out, cfg_pin_oe_out;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          k;

    // Main clock and an unrelated link clock
    always #20 clock_in = ~clock_in;
    initial #7 forever #80 link_clk_in = ~link_clk_in;
    // Quad lines: flash answers 1010 on lines the device leaves
    assign quad_io_in = (quad_io_oe_out & quad_io_out) |
                        (~quad_io_oe_out & 4'ha);

    cps_pin_share DUT (
        .clock_in, .reset_in, .link_clk_in, .config_start_n_in,
        .init_status_n_in, .init_status_oe_out, .done_in, .done_oe_out,
        .scan_sel_in, .master_mode_in, .engine_done_in,
        .slave_chip_select_n_in, .slave_serial_in, .slave_serial_out,
        .slave_serial_oe_out, .eng_sso_in, .eng_ssi_out, .scl_in, .sda_in,
        .sda_oe_out, .eng_sda_low_in, .eng_sda_out, .eng_mclk_in,
        .eng_mcs_n_in, .eng_mdata_in, .eng_mdata_oe_in, .eng_mdata_out,
        .master_clk_out, .master_chip_select_n_out, .master_ctl_oe_out,
        .quad_io_in, .quad_io_out, .quad_io_oe_out, .eng_chain_cs_n_in,
        .chain_select_out_n, .chain_select_oe_out, .user_scan_o_in,
        .user_scan_oe_in, .tdo_in, .scan_pin_out, .scan_pin_oe_out,
        .scan_to_tap_out, .user_o_in, .user_oe_in, .cfg_pin_out,
        .cfg_pin_oe_out, .user_mode_out, .mode_out, .pclk_pin_in,
        .primary_clk_out
    );

    cps_host_model host (
        .link_clk_in, .init_oe_in(init_status_oe_out),
        .done_oe_in(done_oe_out), .sda_oe_in(sda_oe_out),
        .start_n_out(config_start_n_in), .init_n_out(init_status_n_in),
        .done_out(done_in), .cs_n_out(slave_chip_select_n_in),
        .scl_out(scl_in), .sda_out(sda_in)
    );

    // Compare and count
    task chk(input string name, input logic [15:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s exp %h seen %h", name, exp, seen);
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(posedge clock_in);
    endtask : cyc

    // Pin roles of each configuration mode while configuring
    task mode_chk(input logic [2:0] m);
        chk("mode", mode_out, m);
        case (m)
            `CPS_MODE_NONE: chk("tristate", {master_ctl_oe_out,
                chain_select_oe_out, slave_serial_oe_out, sda_oe_out,
                quad_io_oe_out}, 8'h0);
            `CPS_MODE_SSPI: chk("slave", {slave_serial_oe_out,
                slave_serial_out, eng_ssi_out},
                {1'b1, eng_sso_in, slave_serial_in});
            `CPS_MODE_I2C: chk("i2c", {sda_oe_out, eng_sda_out}, 2'b10);
            `CPS_MODE_MSPI: chk("master", {master_ctl_oe_out,
                master_clk_out, master_chip_select_n_out, eng_mdata_out[1]},
                {1'b1, eng_mclk_in, eng_mcs_n_in, 1'b1});
            `CPS_MODE_QSPI: chk("quad", {quad_io_oe_out, eng_mdata_out,
                quad_io_out & quad_io_oe_out},
                {eng_mdata_oe_in, 4'he, 4'h4});
            default: chk("chain", {chain_select_oe_out, chain_select_out_n},
                {1'b1, eng_chain_cs_n_in});
        endcase
    endtask : mode_chk

    // One configuration pass with the host holding its handshake lines
    task config_run(input logic [2:0] m, strap, input bit restart, early);
        host.hold_init <= 1'b1;
        engine_done_in <= early;
        if (restart) begin
            host.start_low <= 1'b1;
            cyc(4);
            host.start_low <= 1'b0;
            for (k = 0; k < 6 && init_status_oe_out !== 1'b1; k++) cyc(1);
            chk("init pull", init_status_oe_out, 1'b1);
            chk("left user", user_mode_out, 1'b0);
        end
        master_mode_in <= strap;
        if (m == `CPS_MODE_SSPI) host.cs_low <= 1'b1;
        cyc(14);
        chk("init free", init_status_oe_out, 1'b0);
        chk("done pull", done_oe_out, 1'b1);
        if (!early) begin
            host.hold_init <= 1'b0;
            if (m == `CPS_MODE_I2C) host.i2c_start();
            cyc(12);
        end
        mode_chk(m);
        host.hold_init <= 1'b0;
        engine_done_in <= 1'b1;
        host.hold_done <= 1'b1;
        for (k = 0; k < 8 && done_oe_out !== 1'b0; k++) cyc(1);
        chk("done free", done_oe_out, 1'b0);
        cyc(8);
        chk("wake held", user_mode_out, 1'b0);
        host.hold_done <= 1'b0;
        for (k = 0; k < 6 && user_mode_out !== 1'b1; k++) cyc(1);
        chk("woke", user_mode_out, 1'b1);
        {host.cs_low, host.scl_low} <= 2'b00;
        master_mode_in <= 3'h0;
        engine_done_in <= 1'b0;
    endtask : config_run

    // User-mode pin roles under two opposite patterns
    task user_chk;
        for (int p = 0; p < 2; p++) begin
            {user_o_in, user_oe_in} <= p ? 32'h5a3c0ff0 : 32'ha5c3f00f;
            {user_scan_o_in, user_scan_oe_in} <= p ? 8'h69 : 8'h96;
            {slave_serial_in, tdo_in, pclk_pin_in} <= p ? 4'h5 : 4'ha;
            cyc(4);
            chk("pin oe", cfg_pin_oe_out, user_oe_in);
            chk("pin", cfg_pin_out & user_oe_in, user_o_in & user_oe_in);
            chk("scan user", {scan_pin_oe_out, scan_pin_out},
                {user_scan_oe_in, user_scan_o_in});
            chk("pclk", primary_clk_out, pclk_pin_in);
            scan_sel_in <= 1'b1;
            cyc(4);
            chk("scan", {scan_pin_oe_out, scan_pin_out[1]}, {4'h2, tdo_in});
            chk("tap", scan_to_tap_out, {slave_serial_in,
                slave_chip_select_n_in, scl_in});
            scan_sel_in <= 1'b0;
        end
    endtask : user_chk

    task results;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results

    // Main sequence
    initial begin
        {scan_sel_in, engine_done_in, slave_serial_in, eng_sso_in} = 4'h2;
        {eng_sda_low_in, eng_mclk_in, eng_mcs_n_in, eng_chain_cs_n_in} = 4'hc;
        {tdo_in, pclk_pin_in, master_mode_in} = 6'h0;
        {eng_mdata_in, eng_mdata_oe_in} = 8'h45;
        {user_o_in, user_oe_in, user_scan_o_in, user_scan_oe_in} = '0;
        cyc(20);
        chk("reset", {init_status_oe_out, done_oe_out, user_mode_out},
            3'h6);
        reset_in <= 1'b0;
        config_run(`CPS_MODE_NONE, 3'h0, 1'b0, 1'b1);
        user_chk();
        for (int m = 1; m < 6; m++)
            config_run(m[2:0], (m > 2) ? m[2:0] : 3'h0, 1'b1, 1'b0);
        user_chk();
        results();
    end

    // Watchdog well beyond the expected run length
    initial begin
        cyc(3000);
        miscompares++;
        results();
    end
endmodule : cps_pin_share_test
